// file: rtl/dcm_pkg.sv
// Package for the DRAM command and mode logic: command codes, mode fields, timing counts.
// Assumes a single 20 MHz clock domain; no bus, all controls are plain ports.
package dcm_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 50;
	// Geometry
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 14;
	localparam int COL_W = 10;
	// Command codes {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	// Address bit that selects auto precharge / all banks
	localparam int AP_BIT = 10;
	// Mode word fields
	localparam int MF_BL_LO = 0;
	localparam int MF_BT = 3;
	localparam int MF_CL_LO = 4;
	localparam int MF_DLLRST = 8;
	localparam int MF_WR_LO = 9;
	localparam int MF_RSV_LO = 13;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	// Reset value of the mode word
	localparam logic [12:0] MODE_RESET = 13'h0032;
	// Mode register index on the bank address
	localparam logic [2:0] MODE_SEL_MAIN = 3'h0;
	// Precharge period in ns and cycles (least time, rounded up)
	localparam int PRECHARGE_PERIOD_NS = 15;
	localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
endpackage

// file: rtl/dcm_burst_order.sv
// Column order generator for one beat of a burst.
// Combinational; driven by the main command logic on the same clock.
`timescale 1ns/10ps
module dcm_burst_order
	import dcm_pkg::*;
(
	// Burst setup
	input wire logic [COL_W-1:0] start_col,
	input wire logic eight,
	input wire logic interleave,
	input wire logic [2:0] beat,
	// Resulting column
	output logic [COL_W-1:0] col
);
	logic [2:0] low;
	// Wrapping low bits inside the aligned block
	always_comb begin
		if (interleave) begin
			low = start_col[2:0] ^ beat;
		end else begin
			low[1:0] = start_col[1:0] + beat[1:0];
			low[2] = start_col[2] ^ beat[2];
		end
		if (!eight) begin
			col = {start_col[COL_W-1:2], low[1:0]};
		end else begin
			col = {start_col[COL_W-1:3], low};
		end
	end
endmodule

// file: rtl/dcm_core.sv
// Command decoder, bank state and mode register of a DDR2-style DRAM die.
// Assumes the controller keeps its ordering duties; pins arrive on CLK.
// Function
// - Chip select high blocks new commands
// - All-high command is a no-op
// - Bank address picks register, address gives contents
// - Activate opens row until precharge
// - Read bursts from column, A10 auto precharges
// - Write bursts to column, A10 auto precharges
// - Reads and writes delayed by additive latency
// - Mask high leaves byte unwritten
// - Precharge one or all banks, then wait
// - Other banks accessible during auto precharge
// - Repeated precharge restarts the period
// - Refresh row address generated internally
// - Refresh with clock enable low: self refresh
// - Delay loop off in self refresh
// - Mode load replaces all; reset bit self-clears
// - High mode bits reserved as zero
// - Burst length four or eight
// - Burst wraps inside aligned block
// - M3 picks sequential or interleaved
// - Interleave xor; sequential nibble increment
// - Read latency three to seven; code only reports the field, reads not delayed
// - Write recovery delays auto precharge
`timescale 1ns/10ps
module dcm_core
	import dcm_pkg::*;
#(
	parameter int AL_MAX = 7
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Command pins
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [BANK_W-1:0] BA,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic DM,
	// Configuration
	input wire logic [2:0] POSTED_ADDITIVE_LATENCY,
	// Array access
	output logic ACC_VALID,
	output logic ACC_WRITE,
	output logic ACC_WE,
	output logic [BANK_W-1:0] ACC_BANK,
	output logic [ADDR_W-1:0] ACC_ROW,
	output logic [COL_W-1:0] ACC_COL,
	// Status
	output logic [NUM_BANKS-1:0] ROW_OPEN,
	output logic [NUM_BANKS-1:0] BANK_READY,
	output logic [ADDR_W-1:0] REFRESH_ROW,
	output logic REFRESH_PULSE,
	output logic SELF_REFRESH,
	output logic DLL_ON,
	output logic DLL_RESET_PULSE,
	output logic [12:0] MODE_CONFIG_WORD,
	output logic [2:0] READ_LATENCY_SETTING,
	output logic [3:0] BURST_LEN_SETTING,
	output logic [3:0] WRITE_RECOVERY_SETTING
);
	// Elaboration check: posted line needs one to seven stages
	if (AL_MAX < 1 || AL_MAX > 7) begin : g_bad_al
		$error("AL_MAX out of range");
	end

	typedef enum logic [2:0] {
		DCM_IDLE = 3'h1,
		DCM_BURST = 3'h2,
		DCM_RECOV = 3'h4
	} dcm_burst_e;

	typedef struct packed {
		logic [2:0] cmd_s1, cmd_s2;       // Synchroniser stages for command
		logic cs_s1, cs_s2, cke_s1, cke_s2, dm_s1, dm_s2;
		logic [BANK_W-1:0] ba_s1, ba_s2;
		logic [ADDR_W-1:0] a_s1, a_s2;
		logic [AL_MAX:0] pv;              // Posted command valid line
		logic [AL_MAX:0] pw;              // Posted write flag line
		logic [AL_MAX:0] pap;             // Posted auto precharge line
		logic [AL_MAX:0][BANK_W-1:0] pb;  // Posted bank line
		logic [AL_MAX:0][COL_W-1:0] pc;   // Posted column line
		dcm_burst_e st;
		logic [2:0] beat;
		logic bwr, bap;
		logic [BANK_W-1:0] bbank;
		logic [COL_W-1:0] bcol;
		logic [3:0] rcnt;
		logic [NUM_BANKS-1:0] open;
		logic [NUM_BANKS-1:0][ADDR_W-1:0] row;
		logic [NUM_BANKS-1:0][CNT_W-1:0] pcnt;
		logic [12:0] mode;
		logic dllrst, self, dll;
		logic [ADDR_W-1:0] rrow;
		logic rpulse;
		logic acc_v, acc_w, acc_we;
		logic [BANK_W-1:0] acc_b;
		logic [ADDR_W-1:0] acc_r;
		logic [COL_W-1:0] acc_c;
		logic [NUM_BANKS-1:0] rdy;        // Registered bank ready
		logic [3:0] bl;                   // Registered burst length
		logic [3:0] wr;                   // Registered write recovery
	} dcm_state_s;

	dcm_state_s cur_ff, nxt_ff;
	logic [COL_W-1:0] beat_col;
	logic [2:0] cmd;
	logic sel;

	// Column order for current beat
	dcm_burst_order u_order (
		.start_col(cur_ff.bcol),
		.eight(cur_ff.mode[MF_BL_LO +: 3] == BL_EIGHT),
		.interleave(cur_ff.mode[MF_BT]),
		.beat(cur_ff.beat),
		.col(beat_col)
	);

	// Precharge timer start for one bank
	function automatic logic [CNT_W-1:0] pre_start();
		return CNT_W'(PRECHARGE_CYC);
	endfunction

	assign cmd = cur_ff.cmd_s2;
	assign sel = !cur_ff.cs_s2;

	// Next-state logic
	always_comb begin
		int al;
		int i;
		al = 0;
		i = 0;
		nxt_ff = cur_ff;
		// Pin synchronisers
		nxt_ff.cmd_s1 = {RAS_N, CAS_N, WE_N};
		nxt_ff.cmd_s2 = cur_ff.cmd_s1;
		nxt_ff.cs_s1 = CS_N;
		nxt_ff.cs_s2 = cur_ff.cs_s1;
		nxt_ff.cke_s1 = CKE;
		nxt_ff.cke_s2 = cur_ff.cke_s1;
		nxt_ff.dm_s1 = DM;
		nxt_ff.dm_s2 = cur_ff.dm_s1;
		nxt_ff.ba_s1 = BA;
		nxt_ff.ba_s2 = cur_ff.ba_s1;
		nxt_ff.a_s1 = ADDR;
		nxt_ff.a_s2 = cur_ff.a_s1;
		nxt_ff.dllrst = 1'b0;
		nxt_ff.rpulse = 1'b0;
		nxt_ff.acc_v = 1'b0;
		nxt_ff.acc_we = 1'b0;
		// Precharge timers count down
		for (i = 0; i < NUM_BANKS; i++) begin
			if (cur_ff.pcnt[i] != '0) nxt_ff.pcnt[i] = cur_ff.pcnt[i] - 1'b1;
		end
		// Posted line shifts toward index 0
		nxt_ff.pv = {1'b0, cur_ff.pv[AL_MAX:1]};
		nxt_ff.pw = {1'b0, cur_ff.pw[AL_MAX:1]};
		nxt_ff.pap = {1'b0, cur_ff.pap[AL_MAX:1]};
		for (i = 0; i < AL_MAX; i++) begin
			nxt_ff.pb[i] = cur_ff.pb[i+1];
			nxt_ff.pc[i] = cur_ff.pc[i+1];
		end
		// Self refresh exit when clock enable returns
		if (cur_ff.self && cur_ff.cke_s2) begin
			nxt_ff.self = 1'b0;
			nxt_ff.dll = 1'b1;
			nxt_ff.dllrst = 1'b1;
		end else if (sel && !cur_ff.self && cmd != CMD_NOP) begin
			case (cmd)
				CMD_MODE: begin
					if (cur_ff.ba_s2 == MODE_SEL_MAIN) begin
						nxt_ff.mode = cur_ff.a_s2[12:0];
						nxt_ff.dllrst = cur_ff.a_s2[MF_DLLRST];
						nxt_ff.mode[MF_DLLRST] = 1'b0;
					end
				end
				CMD_ACTIVATE: begin
					nxt_ff.open[cur_ff.ba_s2] = 1'b1;
					nxt_ff.row[cur_ff.ba_s2] = cur_ff.a_s2;
				end
				CMD_READ, CMD_WRITE: begin
					al = int'(POSTED_ADDITIVE_LATENCY);
					if (al > AL_MAX) al = AL_MAX;
					nxt_ff.pv[al] = 1'b1;
					nxt_ff.pw[al] = (cmd == CMD_WRITE);
					nxt_ff.pap[al] = cur_ff.a_s2[AP_BIT];
					nxt_ff.pb[al] = cur_ff.ba_s2;
					nxt_ff.pc[al] = cur_ff.a_s2[COL_W-1:0];
				end
				CMD_PRECHARGE: begin
					for (i = 0; i < NUM_BANKS; i++) begin
						if (cur_ff.a_s2[AP_BIT] || cur_ff.ba_s2 == BANK_W'(i)) begin
							nxt_ff.open[i] = 1'b0;
							nxt_ff.pcnt[i] = pre_start();
						end
					end
				end
				CMD_REFRESH: begin
					if (!cur_ff.cke_s2) begin
						nxt_ff.self = 1'b1;
						nxt_ff.dll = 1'b0;
					end else begin
						nxt_ff.rrow = cur_ff.rrow + 1'b1;
						nxt_ff.rpulse = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		// Burst engine; a new posted command restarts it
		if (cur_ff.pv[0]) begin
			nxt_ff.st = DCM_BURST;
			nxt_ff.beat = 3'h0;
			nxt_ff.bwr = cur_ff.pw[0];
			nxt_ff.bap = cur_ff.pap[0];
			nxt_ff.bbank = cur_ff.pb[0];
			nxt_ff.bcol = cur_ff.pc[0];
			// Previous auto precharge bank, if not the new command's bank, closes and starts its precharge now
			if (cur_ff.st != DCM_IDLE && cur_ff.bap && cur_ff.bbank != cur_ff.pb[0]) begin
				nxt_ff.open[cur_ff.bbank] = 1'b0;
				nxt_ff.pcnt[cur_ff.bbank] = pre_start();
			end
		end else begin
			case (cur_ff.st)
				DCM_BURST: begin
					nxt_ff.beat = cur_ff.beat + 3'h1;
					if (cur_ff.beat == 3'(BURST_LEN_SETTING - 4'h1)) begin
						if (!cur_ff.bap) begin
							nxt_ff.st = DCM_IDLE;
						end else if (cur_ff.bwr) begin
							nxt_ff.st = DCM_RECOV;
							nxt_ff.rcnt = WRITE_RECOVERY_SETTING;
						end else begin
							nxt_ff.st = DCM_IDLE;
							nxt_ff.open[cur_ff.bbank] = 1'b0;
							nxt_ff.pcnt[cur_ff.bbank] = pre_start();
						end
					end
				end
				DCM_RECOV: begin
					nxt_ff.rcnt = cur_ff.rcnt - 4'h1;
					if (cur_ff.rcnt <= 4'h1) begin
						nxt_ff.st = DCM_IDLE;
						nxt_ff.open[cur_ff.bbank] = 1'b0;
						nxt_ff.pcnt[cur_ff.bbank] = pre_start();
					end
				end
				default: begin
				end
			endcase
		end
		// Array access per beat
		if (cur_ff.st == DCM_BURST) begin
			nxt_ff.acc_v = 1'b1;
			nxt_ff.acc_w = cur_ff.bwr;
			nxt_ff.acc_we = cur_ff.bwr && !cur_ff.dm_s2;
			nxt_ff.acc_b = cur_ff.bbank;
			nxt_ff.acc_r = cur_ff.row[cur_ff.bbank];
			nxt_ff.acc_c = beat_col;
		end
		// Registered views of bank readiness and mode fields
		for (i = 0; i < NUM_BANKS; i++) begin
			nxt_ff.rdy[i] = (nxt_ff.pcnt[i] == '0) && !nxt_ff.open[i];
		end
		nxt_ff.bl = (nxt_ff.mode[MF_BL_LO +: 3] == BL_EIGHT) ? 4'h8 : 4'h4;
		nxt_ff.wr = 4'(nxt_ff.mode[MF_WR_LO +: 3]) + 4'h1;
	end

	// State register
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cur_ff <= '0;
			cur_ff.cmd_s1 <= CMD_NOP;
			cur_ff.cmd_s2 <= CMD_NOP;
			cur_ff.cs_s1 <= 1'b1;
			cur_ff.cs_s2 <= 1'b1;
			cur_ff.cke_s1 <= 1'b1;
			cur_ff.cke_s2 <= 1'b1;
			cur_ff.st <= DCM_IDLE;
			cur_ff.mode <= MODE_RESET;
			cur_ff.dll <= 1'b1;
			cur_ff.rdy <= '1;
			cur_ff.bl <= 4'h4;
			cur_ff.wr <= 4'h1;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Outputs straight from state flops
	assign ACC_VALID = cur_ff.acc_v;
	assign ACC_WRITE = cur_ff.acc_w;
	assign ACC_WE = cur_ff.acc_we;
	assign ACC_BANK = cur_ff.acc_b;
	assign ACC_ROW = cur_ff.acc_r;
	assign ACC_COL = cur_ff.acc_c;
	assign ROW_OPEN = cur_ff.open;
	assign REFRESH_ROW = cur_ff.rrow;
	assign REFRESH_PULSE = cur_ff.rpulse;
	assign SELF_REFRESH = cur_ff.self;
	assign DLL_ON = cur_ff.dll;
	assign DLL_RESET_PULSE = cur_ff.dllrst;
	assign MODE_CONFIG_WORD = cur_ff.mode;
	assign READ_LATENCY_SETTING = cur_ff.mode[MF_CL_LO +: 3];
	assign BURST_LEN_SETTING = cur_ff.bl;
	assign WRITE_RECOVERY_SETTING = cur_ff.wr;
	// Bank ready once its row is closed and its precharge period has run out
	assign BANK_READY = cur_ff.rdy;

	// Checks
	property p_deselect;
		@(posedge CLK) disable iff (SYS_RST)
		(cur_ff.cs_s2 && !cur_ff.self && !cur_ff.pv[0]) |=> (cur_ff.mode == $past(cur_ff.mode));
	endproperty
	a_deselect: assert property (p_deselect) else $error("mode changed while deselected");
	property p_activate;
		@(posedge CLK) disable iff (SYS_RST)
		(sel && !cur_ff.self && cmd == CMD_ACTIVATE) |=> cur_ff.open[$past(cur_ff.ba_s2)];
	endproperty
	a_activate: assert property (p_activate) else $error("activate did not open row");
	property p_dllrst;
		@(posedge CLK) disable iff (SYS_RST) cur_ff.dllrst |-> !cur_ff.mode[MF_DLLRST];
	endproperty
	a_dllrst: assert property (p_dllrst) else $error("reset bit stuck");
	property p_self;
		@(posedge CLK) disable iff (SYS_RST) cur_ff.self |-> !cur_ff.dll;
	endproperty
	a_self: assert property (p_self) else $error("loop on in self refresh");
	property p_mask;
		@(posedge CLK) disable iff (SYS_RST)
		(cur_ff.st == DCM_BURST && cur_ff.bwr && cur_ff.dm_s2 && !cur_ff.pv[0]) |=> !ACC_WE;
	endproperty
	a_mask: assert property (p_mask) else $error("masked byte written");
	property p_prech;
		@(posedge CLK) disable iff (SYS_RST)
		(sel && !cur_ff.self && cmd == CMD_PRECHARGE && !cur_ff.a_s2[AP_BIT])
		|=> !BANK_READY[$past(cur_ff.ba_s2)];
	endproperty
	a_prech: assert property (p_prech) else $error("bank ready too early");
	property p_post;
		@(posedge CLK) disable iff (SYS_RST) cur_ff.pv[0] |=> cur_ff.st == DCM_BURST;
	endproperty
	a_post: assert property (p_post) else $error("posted command lost");
	property p_refresh;
		@(posedge CLK) disable iff (SYS_RST) REFRESH_PULSE |-> REFRESH_ROW == $past(REFRESH_ROW) + 1'b1;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh row not stepped");
	c_write: cover property (@(posedge CLK) ACC_WE);
	c_self: cover property (@(posedge CLK) SELF_REFRESH);
	c_recov: cover property (@(posedge CLK) cur_ff.st == DCM_RECOV);
endmodule

// file: tb/dcm_ctrl_model.sv
// Controller model: drives the command, bank and address pins.
// Assumes one bench process calls its tasks; all pins change after clk.
`timescale 1ns/10ps
module dcm_ctrl_model
	import dcm_pkg::*;
(
	// Clock
	input wire logic clk,
	// Command pins
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [BANK_W-1:0] ba,
	output logic [ADDR_W-1:0] addr,
	output logic dm
);
	// Idle pins at time zero
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = CMD_NOP;
		ba = 3'h0;
		addr = 14'h0000;
		dm = 1'b1;
	end
	// Clock enable and mask levels
	task automatic pins(input logic k, input logic m);
		@(posedge clk);
		cke <= k;
		dm <= m;
	endtask
	// One command, then deselect with the command, bank and address lines turned over
	task automatic cmd(input logic s, input logic [2:0] c, input logic [2:0] b,
		input logic [13:0] a, input int gap);
		@(posedge clk);
		cs_n <= s;
		{ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		@(posedge clk);
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= ~c;
		ba <= ~b;
		addr <= ~a;
		// Spacing after every command, gap cycles long
		repeat (gap) @(posedge clk);
	endtask
endmodule

// file: tb/dcm_core_tb_top.sv
// Bench for dcm_core: burst table rows in a loop, then hand tests.
// Assumes the controller model drives every command pin.
`timescale 1ns/10ps
module dcm_core_tb_top
	import dcm_pkg::*;
;
	// Table row: mode word, latency, start, beats, columns
	typedef struct packed {
		logic [12:0] mode;
		logic [2:0] al;
		logic [2:0] st;
		logic [3:0] nb;
		logic [31:0] cols;
	} dcm_row_s;
	// Pins and outputs
	logic CLK, SYS_RST, CKE, CS_N, RAS_N, CAS_N, WE_N, DM;
	logic ACC_VALID, ACC_WRITE, ACC_WE, REFRESH_PULSE, SELF_REFRESH, DLL_ON, DLL_RESET_PULSE;
	logic [BANK_W-1:0] BA, ACC_BANK;
	logic [ADDR_W-1:0] ADDR, ACC_ROW, REFRESH_ROW, r0;
	logic [2:0] POSTED_ADDITIVE_LATENCY, READ_LATENCY_SETTING;
	logic [COL_W-1:0] ACC_COL;
	logic [NUM_BANKS-1:0] ROW_OPEN, BANK_READY;
	logic [12:0] MODE_CONFIG_WORD;
	logic [3:0] BURST_LEN_SETTING, WRITE_RECOVERY_SETTING;
	// Counters and table
	int bad_count = 0, num_checks = 0, refs = 0, dllr = 0, lat0, lat;
	dcm_row_s rows [6];
	dcm_row_s r;
	dcm_core i_dcm_core (.CLK, .SYS_RST, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .ADDR,
		.DM, .POSTED_ADDITIVE_LATENCY, .ACC_VALID, .ACC_WRITE, .ACC_WE, .ACC_BANK,
		.ACC_ROW, .ACC_COL, .ROW_OPEN, .BANK_READY, .REFRESH_ROW, .REFRESH_PULSE,
		.SELF_REFRESH, .DLL_ON, .DLL_RESET_PULSE, .MODE_CONFIG_WORD,
		.READ_LATENCY_SETTING, .BURST_LEN_SETTING, .WRITE_RECOVERY_SETTING);
	dcm_ctrl_model i_dcm_ctrl_model (.clk(CLK), .cke(CKE), .cs_n(CS_N), .ras_n(RAS_N),
		.cas_n(CAS_N), .we_n(WE_N), .ba(BA), .addr(ADDR), .dm(DM));
	// 20 MHz clock
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// Count one-cycle pulses
	always @(posedge CLK) begin
		if (REFRESH_PULSE === 1'b1) refs++;
		if (DLL_RESET_PULSE === 1'b1) dllr++;
	end
	// Compare one value
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts, verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Wait whole cycles, landing on a falling edge
	task automatic w(input int n);
		repeat (n) @(negedge CLK);
	endtask
	// Command with settle time
	task automatic c(input logic [2:0] k, input logic [2:0] b, input logic [13:0] a);
		i_dcm_ctrl_model.cmd(1'b0, k, b, a, 4);
		w(1);
	endtask
	// Mode load on a chosen register index
	task automatic ml(input logic [2:0] b, input logic [12:0] m);
		c(CMD_MODE, b, {1'b0, m});
	endtask
	// Collect one burst and compare order, place and mask
	task automatic burst(input logic [2:0] b, input logic [13:0] rw, input logic [9:0] c0,
		input logic [31:0] cols, input int nb, input logic wr, input logic we, output int lt);
		int n;
		n = 0;
		lt = -1;
		for (int k = 1; k < 40; k++) begin
			@(negedge CLK);
			if (ACC_VALID === 1'b1 && n < 8) begin
				if (n == 0) lt = k;
				check("col", ACC_COL, {c0[9:3], cols[30-4*n -: 3]});
				check("place", {ACC_BANK, ACC_ROW}, {b, rw});
				check("dir", {ACC_WRITE, ACC_WE}, {wr, we});
				n++;
			end
		end
		check("beats", n, nb);
	endtask
	// Watchdog
	initial begin
		repeat (4000) @(posedge CLK);
		bad_count++;
		results();
	end
	// Main sequence
	initial begin
		SYS_RST = 1'b1;
		POSTED_ADDITIVE_LATENCY = 3'h0;
		rows[0] = '{13'h0032, 3'h0, 3'h5, 4'h4, 32'h56740000};
		rows[1] = '{13'h003A, 3'h2, 3'h1, 4'h4, 32'h10320000};
		rows[2] = '{13'h0033, 3'h1, 3'h5, 4'h8, 32'h56741230};
		rows[3] = '{13'h003B, 3'h3, 3'h6, 4'h8, 32'h67452301};
		rows[4] = '{13'h0043, 3'h0, 3'h3, 4'h8, 32'h30127456};
		rows[5] = '{13'h007A, 3'h0, 3'h3, 4'h4, 32'h32100000};
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = rows[i];
			@(posedge CLK);
			POSTED_ADDITIVE_LATENCY <= r.al;
			ml(3'h0, r.mode);
			check("bl", BURST_LEN_SETTING, (r.mode[2:0] == BL_EIGHT) ? 4'h8 : 4'h4);
			check("cl", READ_LATENCY_SETTING, r.mode[6:4]);
			c(CMD_ACTIVATE, i[2:0], {11'h246, i[2:0]});
			check("open", ROW_OPEN[i], 1'b1);
			i_dcm_ctrl_model.cmd(1'b0, CMD_READ, i[2:0], {4'h0, 7'h75, r.st}, 0);
			burst(i[2:0], {11'h246, i[2:0]}, {7'h75, r.st}, r.cols, r.nb, 1'b0, 1'b0, lat);
			if (i == 0) lat0 = lat;
			if (r.mode[6:4] == 3'h3) check("lat", lat, lat0 + r.al);
			c(CMD_PRECHARGE, 3'h0, 14'h0400);
			check("ready", BANK_READY, 8'hFF);
			$display("test row %0d done", i);
		end
		// Reset in mid-run
		@(posedge CLK);
		SYS_RST <= 1'b1;
		w(4);
		@(posedge CLK);
		SYS_RST <= 1'b0;
		w(2);
		check("rst", {MODE_CONFIG_WORD, DLL_ON, SELF_REFRESH}, {13'h0032, 2'h2});
		$display("test reset done");
		// Masked write with auto precharge, then plain write
		ml(3'h0, 13'h0232);
		check("wr", WRITE_RECOVERY_SETTING, 4'h2);
		c(CMD_ACTIVATE, 3'h2, 14'h0155);
		i_dcm_ctrl_model.cmd(1'b0, CMD_WRITE, 3'h2, 14'h0408, 0);
		burst(3'h2, 14'h0155, 10'h008, 32'h01230000, 4, 1'b1, 1'b0, lat);
		check("ap", {ROW_OPEN[2], BANK_READY[2]}, 2'h1);
		i_dcm_ctrl_model.pins(1'b1, 1'b0);
		c(CMD_ACTIVATE, 3'h2, 14'h0155);
		i_dcm_ctrl_model.cmd(1'b0, CMD_WRITE, 3'h2, 14'h000C, 0);
		burst(3'h2, 14'h0155, 10'h00C, 32'h45670000, 4, 1'b1, 1'b1, lat);
		check("keep", ROW_OPEN[2], 1'b1);
		$display("test write done");
		// Single, repeated and all-bank precharge
		c(CMD_ACTIVATE, 3'h5, 14'h0011);
		c(CMD_PRECHARGE, 3'h2, 14'h0000);
		check("one", ROW_OPEN, 8'h20);
		c(CMD_PRECHARGE, 3'h2, 14'h0000);
		check("again", BANK_READY[2], 1'b1);
		c(CMD_PRECHARGE, 3'h0, 14'h0400);
		check("all", ROW_OPEN, 8'h00);
		// Deselect and no-op leave state alone
		i_dcm_ctrl_model.cmd(1'b1, CMD_ACTIVATE, 3'h4, 14'h0001, 4);
		w(1);
		check("desel", ROW_OPEN, 8'h00);
		c(CMD_NOP, 3'h0, 14'h0000);
		check("nop", MODE_CONFIG_WORD, 13'h0232);
		$display("test select done");
		// Refresh row comes from inside
		r0 = REFRESH_ROW;
		c(CMD_REFRESH, 3'h5, 14'h2AAA);
		check("rrow", REFRESH_ROW, r0 + 14'h0001);
		c(CMD_REFRESH, 3'h2, 14'h1555);
		check("rrow2", {REFRESH_ROW, refs[3:0]}, {r0 + 14'h0002, 4'h2});
		// Self refresh entry, commands ignored, exit
		i_dcm_ctrl_model.pins(1'b0, 1'b0);
		c(CMD_REFRESH, 3'h0, 14'h0000);
		check("sr", {SELF_REFRESH, DLL_ON}, 2'h2);
		c(CMD_ACTIVATE, 3'h1, 14'h0001);
		check("sr_ign", ROW_OPEN, 8'h00);
		i_dcm_ctrl_model.pins(1'b1, 1'b0);
		w(6);
		check("sr_exit", {SELF_REFRESH, DLL_ON, dllr[3:0]}, 6'h11);
		$display("test refresh done");
		// Mode register index and whole-word replace
		ml(3'h1, 13'h0A73);
		check("idx", MODE_CONFIG_WORD, 13'h0232);
		ml(3'h0, 13'h0A73);
		check("mw", MODE_CONFIG_WORD, 13'h0A73);
		check("fields", {READ_LATENCY_SETTING, BURST_LEN_SETTING, WRITE_RECOVERY_SETTING},
			11'h786);
		ml(3'h0, 13'h0132);
		check("m8", {MODE_CONFIG_WORD, dllr[3:0]}, {13'h0032, 4'h2});
		$display("test mode done");
		results();
	end
endmodule
